// [mrr_pkg.sv]
// Constants, register map and state types for the round-robin configuration bank.
// Assumes a serial front end on ref_clk that delivers decoded byte accesses.
package mrr_pkg;

    // Register byte offsets
    localparam logic [7:0] MRR_OFF_CYCLE_EN   = 8'h06;
    localparam logic [7:0] MRR_OFF_CHAN_MASK  = 8'h07;
    localparam logic [7:0] MRR_OFF_EDGE_SEL   = 8'h09;
    localparam logic [7:0] MRR_OFF_RESET_KEY  = 8'h0B;

    // Reset values
    localparam logic [7:0] MRR_RST_CYCLE_EN   = 8'h00;
    localparam logic [7:0] MRR_RST_MASK_EIGHT = 8'hFF;
    localparam logic [7:0] MRR_RST_MASK_FOUR  = 8'h0F;
    localparam logic [7:0] MRR_RST_EDGE_SEL   = 8'h00;
    localparam logic [7:0] MRR_RST_RESET_KEY  = 8'h00;

    // Writable bits of the channel mask register in each variant
    localparam logic [7:0] MRR_WMASK_EIGHT    = 8'hFF;
    localparam logic [7:0] MRR_WMASK_FOUR     = 8'h0F;

    // Field positions
    localparam int unsigned MRR_BIT_CYCLE_EN  = 0;
    localparam int unsigned MRR_BIT_EDGE_RISE = 0;

    // Software reset key sequence
    localparam logic [7:0] MRR_KEY_FIRST      = 8'hA3;
    localparam logic [7:0] MRR_KEY_SECOND     = 8'h05;

    // Channel counts of the two variants
    localparam logic [3:0] MRR_NCHAN_EIGHT    = 4'h8;
    localparam logic [3:0] MRR_NCHAN_FOUR     = 4'h4;

    // Software reset key sequence states
    typedef enum logic [0:0] {
        MRR_KEY_IDLE,
        MRR_KEY_ARMED
    } mrr_key_e;

    // Complete state of the configuration bank
    typedef struct packed {
        logic       cycle_en;
        logic [7:0] chan_mask;
        logic       edge_rise;
        mrr_key_e   key_state;
        logic [2:0] cur_chan;
        logic [7:0] rdata;
        logic       step;
    } mrr_bank_s;

    // Complete state of the strobe synchroniser
    typedef struct packed {
        logic [2:0] sync;
        logic       primed;
        logic       level;
        logic       rise;
        logic       fall;
    } mrr_sync_s;

endpackage : mrr_pkg

// [mrr_strobe_sync.sv]
// Synchroniser and edge detector for the convert strobe pin.
// Assumes the pin is asynchronous to ref_clk and stays stable for two cycles.
`timescale 1ns/10ps
module mrr_strobe_sync
    import mrr_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Pin from outside the clock domain
    input  wire logic strobe_pin,
    // Clean edge pulses
    output logic      rise_pulse,
    output logic      fall_pulse
);

    mrr_sync_s s_q;
    mrr_sync_s s_d;

    // Shift the pin in; a change counts once stages two and three agree
    always_comb begin
        s_d      = s_q;
        s_d.sync = {s_q.sync[1:0], strobe_pin};
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (s_q.sync[1] == s_q.sync[2]) begin
            if (!s_q.primed) begin
                // Reset zeros in stages two and three are the first settled level, with no edge; a pin high from reset then gives a rise
                s_d.primed = 1'b1;
                s_d.level  = s_q.sync[2];
            end else if (s_q.sync[2] != s_q.level) begin
                s_d.level = s_q.sync[2];
                s_d.rise  = s_q.sync[2];
                s_d.fall  = !s_q.sync[2];
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise_pulse = s_q.rise;
    assign fall_pulse = s_q.fall;

endmodule : mrr_strobe_sync

// [mrr_config_bank.sv]
// Round-robin configuration registers of a serially controlled multiplexer.
// Assumes the serial front end decodes frames into one-cycle byte accesses on ref_clk.
`timescale 1ns/10ps
module mrr_config_bank
    import mrr_pkg::*;
#(
    parameter logic FOUR_CHAN = 1'b0
)(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Register access from the serial front end
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Convert strobe pin
    input  wire logic       convert_strobe_pin,
    // Sequence state towards the switch drivers
    output logic            cycle_active,
    output logic      [7:0] cycle_channel_mask,
    output logic      [2:0] cycle_channel,
    output logic            cycle_step
);

    // Variant dependent constants
    localparam logic [7:0] MASK_RST = FOUR_CHAN ? MRR_RST_MASK_FOUR : MRR_RST_MASK_EIGHT;
    localparam logic [7:0] MASK_WR  = FOUR_CHAN ? MRR_WMASK_FOUR : MRR_WMASK_EIGHT;
    localparam logic [3:0] NCHAN    = FOUR_CHAN ? MRR_NCHAN_FOUR : MRR_NCHAN_EIGHT;

    mrr_bank_s s_q;
    mrr_bank_s s_d;

    logic      strobe_rise;
    logic      strobe_fall;
    logic      active_edge;
    logic      wr_key;
    logic      wr_key_first;
    logic      wr_key_second;
    logic [2:0] next_chan;

    // Clean strobe edges
    mrr_strobe_sync u_sync (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .strobe_pin (convert_strobe_pin),
        .rise_pulse (strobe_rise),
        .fall_pulse (strobe_fall)
    );

    // Next included channel above the current one, wrapping; holds if none
    function automatic logic [2:0] mrr_next_chan(
        input logic [2:0] cur,
        input logic [7:0] mask
    );
        logic [3:0] idx;
        logic       found;
        mrr_next_chan = cur;
        found         = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            idx = 4'(cur) + 4'(i);
            if (idx >= NCHAN) begin
                idx = idx - NCHAN;
            end
            if (!found && (4'(i) <= NCHAN) && mask[idx[2:0]]) begin
                mrr_next_chan = idx[2:0];
                found         = 1'b1;
            end
        end
    endfunction : mrr_next_chan

    // Edge choice and key decode
    assign active_edge   = s_q.edge_rise ? strobe_rise : strobe_fall;
    assign wr_key        = reg_wr_en && (reg_addr == MRR_OFF_RESET_KEY);
    assign wr_key_first  = wr_key && (reg_wdata == MRR_KEY_FIRST);
    assign wr_key_second = wr_key && (reg_wdata == MRR_KEY_SECOND)
                           && (s_q.key_state == MRR_KEY_ARMED);
    assign next_chan     = mrr_next_chan(s_q.cur_chan, s_q.chan_mask);

    // Register writes, key sequence, read data and channel stepping
    always_comb begin
        s_d      = s_q;
        s_d.step = 1'b0;

        // Round-robin stepping on the chosen strobe edge
        if (s_q.cycle_en && active_edge) begin
            s_d.cur_chan = next_chan;
            s_d.step     = 1'b1;
        end

        // Ordinary register writes; reserved bits are dropped
        if (reg_wr_en) begin
            case (reg_addr)
                MRR_OFF_CYCLE_EN: begin
                    s_d.cycle_en = reg_wdata[MRR_BIT_CYCLE_EN];
                end
                MRR_OFF_CHAN_MASK: begin
                    s_d.chan_mask = reg_wdata & MASK_WR;
                end
                MRR_OFF_EDGE_SEL: begin
                    s_d.edge_rise = reg_wdata[MRR_BIT_EDGE_RISE];
                end
                default: begin
                end
            endcase
        end

        // Key sequence: while armed, any write other than the first or second key disarms
        case (s_q.key_state)
            MRR_KEY_IDLE: begin
                if (wr_key_first) begin
                    s_d.key_state = MRR_KEY_ARMED;
                end
            end
            MRR_KEY_ARMED: begin
                if (reg_wr_en && !wr_key_second) begin
                    s_d.key_state = wr_key_first ? MRR_KEY_ARMED : MRR_KEY_IDLE;
                end
            end
            default: begin
                s_d.key_state = MRR_KEY_IDLE;
            end
        endcase

        // Full software reset of every register except the read data
        if (wr_key_second) begin
            s_d.cycle_en  = MRR_RST_CYCLE_EN[MRR_BIT_CYCLE_EN];
            s_d.chan_mask = MASK_RST;
            s_d.edge_rise = MRR_RST_EDGE_SEL[MRR_BIT_EDGE_RISE];
            s_d.key_state = MRR_KEY_IDLE;
            s_d.cur_chan  = 3'h0;
            s_d.step      = 1'b0;
        end

        // Read data; reserved and unmapped bits read as zero
        if (reg_rd_en) begin
            case (reg_addr)
                MRR_OFF_CYCLE_EN: begin
                    s_d.rdata = {7'h00, s_q.cycle_en};
                end
                MRR_OFF_CHAN_MASK: begin
                    s_d.rdata = s_q.chan_mask & MASK_WR;
                end
                MRR_OFF_EDGE_SEL: begin
                    s_d.rdata = {7'h00, s_q.edge_rise};
                end
                MRR_OFF_RESET_KEY: begin
                    s_d.rdata = MRR_RST_RESET_KEY;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.cycle_en  <= MRR_RST_CYCLE_EN[MRR_BIT_CYCLE_EN];
            s_q.chan_mask <= MASK_RST;
            s_q.edge_rise <= MRR_RST_EDGE_SEL[MRR_BIT_EDGE_RISE];
            s_q.key_state <= MRR_KEY_IDLE;
            s_q.cur_chan  <= 3'h0;
            s_q.rdata     <= 8'h00;
            s_q.step      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata          = s_q.rdata;
    assign cycle_active       = s_q.cycle_en;
    assign cycle_channel_mask = s_q.chan_mask;
    assign cycle_channel      = s_q.cur_chan;
    assign cycle_step         = s_q.step;

endmodule : mrr_config_bank

// [mrr_bank_chk_asserts.sv]
// Port assertions for the round-robin configuration bank.
// Bound into every bank instance; the variant arrives through FOUR_CHAN.
`timescale 1ns/10ps
module mrr_bank_chk
    import mrr_pkg::*;
#(parameter logic FOUR_CHAN = 1'b0) (
    // Clock, reset, register port and sequence state
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       cycle_active,
    input wire logic [7:0] cycle_channel_mask,
    input wire logic [2:0] cycle_channel,
    input wire logic       cycle_step
);
    wire logic [7:0] wm = FOUR_CHAN ? MRR_WMASK_FOUR : MRR_WMASK_EIGHT;
    logic      [7:0] mask_p;
    // Mask that governed the step now showing
    always_ff @(posedge ref_clk) mask_p <= cycle_channel_mask;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_mask_wr; reg_wr_en && reg_addr == MRR_OFF_CHAN_MASK
        |=> cycle_channel_mask == ($past(reg_wdata) & wm); endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");
    property p_resv; (cycle_channel_mask & ~wm) == 8'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved mask bit set");
    property p_en_wr; reg_wr_en && reg_addr == MRR_OFF_CYCLE_EN
        |=> {7'h00, cycle_active} == ($past(reg_wdata) & 8'h01); endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");
    property p_idle; !cycle_active |=> !cycle_step; endproperty
    a_idle: assert property (p_idle) else $error("step while disabled");
    property p_step; cycle_step && mask_p != 8'h00 |-> mask_p[cycle_channel]; endproperty
    a_step: assert property (p_step) else $error("step to skipped channel");
    property p_key_rd; reg_rd_en && reg_addr == MRR_OFF_RESET_KEY
        |=> reg_rdata == 8'h00; endproperty
    a_key_rd: assert property (p_key_rd) else $error("key register not zero");
    property p_edge_rd; reg_rd_en && reg_addr == MRR_OFF_EDGE_SEL
        |=> reg_rdata[7:1] == 7'h00; endproperty
    a_edge_rd: assert property (p_edge_rd) else $error("edge reserved bits set");
    property p_soft; (reg_wr_en && reg_addr == MRR_OFF_RESET_KEY && reg_wdata == MRR_KEY_FIRST)
        ##1 (reg_wr_en && reg_addr == MRR_OFF_RESET_KEY && reg_wdata == MRR_KEY_SECOND)
        |=> !cycle_active && cycle_channel == 3'h0 && cycle_channel_mask == wm; endproperty
    a_soft: assert property (p_soft) else $error("key pair did not reset");
endmodule : mrr_bank_chk
bind mrr_config_bank mrr_bank_chk #(.FOUR_CHAN(FOUR_CHAN)) u_chk (.*);

// [mrr_host_model.sv]
// Host and strobe source driving the bank's register port and pin.
// Every change lands 1 ns after a rising ref_clk edge.
`timescale 1ns/10ps
module mrr_host_model
    import mrr_pkg::*;
(
    // Clock in, register port and pin out
    input  wire logic       ref_clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            convert_strobe_pin
);
    initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, convert_strobe_pin} = 19'h0_0001;
    // One access per call; successive calls run back to back
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {w, !w, a, d};
    endtask : acc
    // Released port shows inverted address and data
    task idle;
        @(posedge ref_clk) #1;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {2'b00, ~reg_addr, ~reg_wdata};
    endtask : idle
    // Pin change; caller holds it for several cycles
    task flip;
        @(posedge ref_clk) #1;
        convert_strobe_pin = !convert_strobe_pin;
    endtask : flip
    // Key pair in consecutive writes
    task key;
        acc(1'b1, MRR_OFF_RESET_KEY, MRR_KEY_FIRST);
        acc(1'b1, MRR_OFF_RESET_KEY, MRR_KEY_SECOND);
    endtask : key
endmodule : mrr_host_model

// [tb.sv]
// Self-checking bench: both bank variants share one host model.
// Reads and steps are noted in queues and checked by a watcher.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    import mrr_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr, rd, pin, step, rd_seen, e_act, e_sel;
    logic  [7:0] addr, wd, rd8, rd4, e_msk, m;
    logic  [2:0] ch8, e_ch, c, sq[$];
    logic [15:0] e, rq[$];
    int          mismatches = 0, num_checks = 0, n;
    mrr_host_model host (.ref_clk(ref_clk), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
        .reg_wdata(wd), .convert_strobe_pin(pin));
    mrr_config_bank DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd8), .convert_strobe_pin(pin),
        .cycle_active(), .cycle_channel_mask(), .cycle_channel(ch8), .cycle_step(step));
    mrr_config_bank #(.FOUR_CHAN(1'b1)) DUT4 (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
        .reg_wdata((addr == MRR_OFF_RESET_KEY) ? wd : (wd & 8'h0F)),
        .reg_rdata(rd4), .convert_strobe_pin(pin), .cycle_active(), .cycle_channel_mask(),
        .cycle_channel(), .cycle_step());
    initial forever #50 ref_clk = !ref_clk;
    always @(posedge ref_clk) rd_seen <= rd;
    // Watcher: oldest note against each read result and each step
    always @(negedge ref_clk) begin
        if (rd_seen) begin
            e = rq.pop_front();
            `CHK("rdata", e, {rd8, rd4})
        end
        if (step) begin
            c = sq.size() ? sq.pop_front() : 3'bxxx;
            `CHK("channel", c, ch8)
        end
    end
    task wr_t(input logic [7:0] a, input logic [7:0] d);
        host.acc(1'b1, a, d);
        if (a == MRR_OFF_CYCLE_EN) e_act = d[0];
        if (a == MRR_OFF_EDGE_SEL) e_sel = d[0];
        if (a == MRR_OFF_CHAN_MASK) e_msk = d;
    endtask : wr_t
    task rd_t(input logic [7:0] a, input logic [7:0] x8, input logic [7:0] x4);
        host.acc(1'b0, a, 8'h00);
        rq.push_back({x8, x4});
    endtask : rd_t
    // Pin change; an active edge moves to the next included channel above
    task fire;
        host.idle();
        host.flip();
        if (e_act && pin == e_sel) begin
            for (n = 1; n < 8 && !e_msk[3'(e_ch + n)]; n++) ;
            e_ch = 3'(e_ch + n);
            sq.push_back(e_ch);
        end
        for (n = 0; n < 8 && !step; n++) @(negedge ref_clk);
        if (n == 8 && sq.size() != 0) begin
            mismatches++;
            test_done();
        end
        repeat (2) @(posedge ref_clk);
    endtask : fire
    task test_done;
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(84));
        {e_act, e_sel, e_msk, e_ch} = {2'b00, MRR_RST_MASK_EIGHT, 3'h0};
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        // Defaults; key register and unmapped place read zero
        rd_t(MRR_OFF_CYCLE_EN, 8'h00, 8'h00);
        rd_t(MRR_OFF_CHAN_MASK, MRR_RST_MASK_EIGHT, MRR_RST_MASK_FOUR);
        wr_t(MRR_OFF_RESET_KEY, 8'h5A);
        rd_t(MRR_OFF_RESET_KEY, 8'h00, 8'h00);
        rd_t(8'h3C, 8'h00, 8'h00);
        // Both polarities, a sparse mask, then a random mask
        for (int s = 0; s < 2; s++) begin
            wr_t(MRR_OFF_EDGE_SEL, 8'(s));
            rd_t(MRR_OFF_EDGE_SEL, 8'(s), 8'(s));
            wr_t(MRR_OFF_CHAN_MASK, 8'h05);
            wr_t(MRR_OFF_CYCLE_EN, 8'h01);
            repeat (4) fire();
            m = 8'($urandom);
            wr_t(MRR_OFF_CHAN_MASK, m);
            rd_t(MRR_OFF_CHAN_MASK, m, m & 8'h0F);
            repeat (6) fire();
        end
        wr_t(MRR_OFF_CYCLE_EN, 8'h00);
        repeat (2) fire();
        // Broken key pair keeps registers, a whole pair restores defaults
        wr_t(MRR_OFF_RESET_KEY, MRR_KEY_FIRST);
        wr_t(MRR_OFF_CHAN_MASK, 8'h0A);
        wr_t(MRR_OFF_RESET_KEY, MRR_KEY_SECOND);
        rd_t(MRR_OFF_CHAN_MASK, 8'h0A, 8'h0A);
        wr_t(MRR_OFF_CYCLE_EN, 8'h01);
        host.key();
        rd_t(MRR_OFF_CYCLE_EN, 8'h00, 8'h00);
        rd_t(MRR_OFF_CHAN_MASK, MRR_RST_MASK_EIGHT, MRR_RST_MASK_FOUR);
        host.idle();
        repeat (3) @(posedge ref_clk);
        test_done();
    end
endmodule : tb
